// [logic/dram_consts.svh]
// constants of the host-side controller for a 1M x 1 dynamic RAM
// assumes a single 25 MHz clock; times are given in ns and turned into cycles here
// Function
// - nibble starts with ordinary row then column access
// - nibble beats only while row strobe low
// - static column reaches any column by address
// - static column starts ordinary, strobes held low
// - every row refreshed within each 8 ms
// - full refresh is 512 row cycles
// - refresh burst or distributed, 15.6 us average
// - no access while a refresh is running
// - refresh methods only in normal random mode
// - row-only refresh: row address, pulse, column high
// - host keeps its own refresh row counter
// - column before row starts internal-counter refresh
// - column strobe held low after row strobe falls
// - hidden refresh: row strobe cycles, column stays low
// - never write during a hidden refresh
`ifndef DRAM_CONSTS_SVH
`define DRAM_CONSTS_SVH

`define CLK_PERIOD_NS                 40
`define CYC_UP(ns)                    (((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`define ROW_ACCESS_DELAY_NS           85
`define NIBBLE_ACCESS_DELAY_NS        20
`define COL_ADDRESS_ACCESS_DELAY_NS   45
`define ROW_STROBE_LOW_WIDTH_NS       85
`define ROW_PRECHARGE_WIDTH_NS        80
`define COL_BEFORE_ROW_SETUP_NS       10
`define COL_BEFORE_ROW_HOLD_NS        15
`define REFRESH_PERIOD_NS             8000000
`define REFRESH_ROWS                  512

`define ACC_CYC   `CYC_UP(`ROW_ACCESS_DELAY_NS)
`define NIB_CYC   `CYC_UP(`NIBBLE_ACCESS_DELAY_NS)
`define SC_CYC    `CYC_UP(`COL_ADDRESS_ACCESS_DELAY_NS)
`define RAS_CYC   `CYC_UP(`ROW_STROBE_LOW_WIDTH_NS)
`define RP_CYC    `CYC_UP(`ROW_PRECHARGE_WIDTH_NS)
`define CSR_CYC   `CYC_UP(`COL_BEFORE_ROW_SETUP_NS)
`define CHR_CYC   `CYC_UP(`COL_BEFORE_ROW_HOLD_NS)
`define REFRESH_PERIOD_CYC (`REFRESH_PERIOD_NS / `CLK_PERIOD_NS)
`define SYNC_CYC  2
`define PEND_URGENT 4'h4
`define FIFO_DEPTH 16

`endif

// [logic/dram_pkg.sv]
// types shared by the dram controller and its testbench
// assumes dram_consts.svh for all numeric values
`default_nettype none
package dram_pkg;

  typedef enum logic [1:0] {MODE_RANDOM, MODE_NIBBLE, MODE_STATIC} mode_t;
  typedef enum logic [1:0] {REF_RAS_ONLY, REF_CBR, REF_HIDDEN} ref_method_t;
  typedef enum logic [2:0] {S_IDLE, S_ROW, S_COL, S_NIB, S_ROR, S_CBR, S_HID} state_t;

  // one user request: up to four bits from one row
  typedef struct packed {
    logic        write;
    mode_t       mode;
    logic [1:0]  extra;   // beats after the first
    logic [19:0] addr;    // row in [19:10], column in [9:0]
    logic [3:0]  wdata;   // bit n written on beat n
  } req_t;

  // registered pin levels
  typedef struct packed {
    logic       ras_n;
    logic       cas_n;    // doubles as chip select in static column mode
    logic       we_n;
    logic [9:0] a;
    logic       d;
  } pins_t;

  typedef struct packed {
    state_t     st;
    logic [3:0] tmr;
    logic [1:0] beat;
    logic [8:0] row_ctr;
    logic [3:0] pend;
    logic [8:0] tick;
    logic       q1;
    logic       q2;
    req_t       req;
    pins_t      pin;
  } ctl_t;

endpackage
`default_nettype wire

// [logic/data_fifo.sv]
// small synchronous fifo, register array with valid/ready on both sides
// assumes depth is a power of two and a single clock
`timescale 1ns/1ps
`default_nettype none
module data_fifo #(
  parameter int W = 1,
  parameter int D = 16
) (
  input  wire logic         clock,
  input  wire logic         nrst,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = $clog2(D);

  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW:0]         wp;
    logic [AW:0]         rp;
  } fst_t;

  fst_t s;
  fst_t next_s;

  ////////////////////////////////////////////////////////////////////
  // full when pointers differ only in the wrap bit
  assign in_ready  = (s.wp ^ s.rp) != {1'b1, {AW{1'b0}}};
  assign out_valid = s.wp != s.rp;
  assign out_data  = s.mem[s.rp[AW-1:0]];

  // pointer and storage update
  always_comb begin
    next_s = s;
    if (in_valid && in_ready) begin
      next_s.mem[s.wp[AW-1:0]] = in_data;
      next_s.wp = s.wp + 1'b1;
    end
    if (out_valid && out_ready) begin
      next_s.rp = s.rp + 1'b1;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

endmodule
`default_nettype wire

// [logic/dram_fast_modes_refresh.sv]
// host-side controller for a 1M x 1 dynamic RAM: random, nibble and static
// column accesses plus row-only, column-before-row and hidden refresh
// assumes the dram pins are wired straight to the device, data in and out
// on separate pins, and one 25 MHz clock
`include "dram_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module dram_fast_modes_refresh #(
  parameter int REFRESH_PERIOD_CYC = `REFRESH_PERIOD_CYC
) (
  input  wire logic                  clock,
  input  wire logic                  nrst,
  input  wire dram_pkg::req_t        req,
  input  wire logic                  req_valid,
  output logic                       req_ready,
  input  wire dram_pkg::ref_method_t ref_method,
  output logic                       rd_data,
  output logic                       rd_valid,
  input  wire logic                  rd_ready,
  output logic                       refreshing,
  output logic                       ras_n,
  output logic                       cas_n,
  output logic                       we_n,
  output logic [9:0]                 addr,
  output logic                       d,
  input  wire logic                  q
);
  localparam int INTERVAL = REFRESH_PERIOD_CYC / `REFRESH_ROWS;

  dram_pkg::ctl_t s;
  dram_pkg::ctl_t next_s;
  logic           push;
  logic           in_ready;
  logic           tick_inc;
  logic           ref_done;
  logic           done;
  logic           due;
  logic           urgent;
  logic           ref_go;
  logic           last;

  ////////////////////////////////////////////////////////////////////
  // pins come straight from registers
  assign ras_n      = s.pin.ras_n;
  assign cas_n      = s.pin.cas_n;
  assign we_n       = s.pin.we_n;
  assign addr       = s.pin.a;
  assign d          = s.pin.d;
  assign refreshing = s.st inside {dram_pkg::S_ROR, dram_pkg::S_CBR, dram_pkg::S_HID};

  // arbitration terms
  assign done   = s.tmr == 4'h0;
  assign due    = s.pend != 4'h0;
  assign urgent = s.pend >= `PEND_URGENT;
  assign ref_go = urgent || (due && !req_valid);
  assign last   = s.beat == s.req.extra;

  // accesses wait while refresh is owed urgently or still running
  assign req_ready = (s.st == dram_pkg::S_IDLE) && done && !ref_go;

  ////////////////////////////////////////////////////////////////////
  // read data buffer; a full buffer holds the access with column low
  data_fifo #(
    .W (1),
    .D (`FIFO_DEPTH)
  ) u_fifo (
    .clock     (clock),
    .nrst      (nrst),
    .in_valid  (push),
    .in_ready  (in_ready),
    .in_data   (s.q2),
    .out_valid (rd_valid),
    .out_ready (rd_ready),
    .out_data  (rd_data)
  );

  ////////////////////////////////////////////////////////////////////
  // next state of the whole controller
  always_comb begin
    next_s   = s;
    push     = 1'b0;
    tick_inc = 1'b0;
    ref_done = 1'b0;
    // two-flop synchroniser on the asynchronous data pin
    next_s.q1 = q;
    next_s.q2 = s.q1;
    if (!done) begin
      next_s.tmr = s.tmr - 4'h1;
    end
    // one refresh owed per interval keeps all 512 rows inside the period
    if (s.tick == 9'h000) begin
      next_s.tick = 9'(INTERVAL - 1);
      tick_inc    = s.pend != 4'hf;
    end else begin
      next_s.tick = s.tick - 9'h001;
    end
    unique case (s.st)
      dram_pkg::S_IDLE: begin
        if (done && ref_go) begin
          if (ref_method == dram_pkg::REF_RAS_ONLY) begin
            // row from own counter; top line is don't care
            next_s.pin.a = {1'b0, s.row_ctr};
            next_s.st    = dram_pkg::S_ROR;
          end else begin
            // no access to hide behind: plain column-before-row
            next_s.pin.cas_n = 1'b0;
            next_s.tmr       = 4'(`CSR_CYC - 1);
            next_s.st        = dram_pkg::S_CBR;
          end
        end else if (done && req_valid) begin
          next_s.req   = req;
          next_s.beat  = 2'h0;
          next_s.pin.a = req.addr[19:10];
          next_s.st    = dram_pkg::S_ROW;
        end
      end
      dram_pkg::S_ROW: begin
        // row strobe falls one cycle after the row address settles
        if (s.pin.ras_n) begin
          next_s.pin.ras_n = 1'b0;
          next_s.tmr       = 4'h0;
        end else begin
          next_s.pin.a     = s.req.addr[9:0];
          next_s.pin.cas_n = 1'b0;
          next_s.pin.we_n  = !s.req.write;
          next_s.pin.d     = s.req.wdata[0];
          next_s.tmr       = 4'(`ACC_CYC - 2 + `SYNC_CYC);
          next_s.st        = dram_pkg::S_COL;
        end
      end
      dram_pkg::S_COL: begin
        // a read that cannot be stored waits with data held on the pin
        if (done && (s.req.write || in_ready)) begin
          push        = !s.req.write;
          next_s.beat = s.beat + 2'h1;
          if (last) begin
            next_s.pin.we_n = 1'b1;
            if (ref_method == dram_pkg::REF_HIDDEN && due &&
                s.req.mode == dram_pkg::MODE_RANDOM) begin
              // keep column low so read data stays valid
              next_s.pin.ras_n = 1'b1;
              next_s.tmr       = 4'(`RP_CYC - 1);
              next_s.st        = dram_pkg::S_HID;
            end else begin
              // raising the row strobe ends any fast sequence
              next_s.pin.ras_n = 1'b1;
              next_s.pin.cas_n = 1'b1;
              next_s.tmr       = 4'(`RP_CYC - 1);
              next_s.st        = dram_pkg::S_IDLE;
            end
          end else if (s.req.mode == dram_pkg::MODE_STATIC) begin
            // select stays low; only the column address and data pin move
            next_s.pin.a = s.req.addr[9:0] + {8'h00, s.beat} + 10'h001;
            next_s.pin.d = s.req.wdata[s.beat + 2'h1];
            next_s.tmr   = 4'(`SC_CYC - 1 + `SYNC_CYC);
          end else if (s.req.mode == dram_pkg::MODE_NIBBLE) begin
            next_s.pin.cas_n = 1'b1;
            next_s.pin.we_n  = 1'b1;
            next_s.st        = dram_pkg::S_NIB;
          end else begin
            // random mode carries a single beat only; a write must not leave
            // write enable low into the next row cycle or a refresh
            next_s.pin.we_n  = 1'b1;
            next_s.pin.ras_n = 1'b1;
            next_s.pin.cas_n = 1'b1;
            next_s.tmr       = 4'(`RP_CYC - 1);
            next_s.st        = dram_pkg::S_IDLE;
          end
        end
      end
      dram_pkg::S_NIB: begin
        // column counter inside the part steps; address left alone
        next_s.pin.cas_n = 1'b0;
        next_s.pin.we_n  = !s.req.write;
        next_s.pin.d     = s.req.wdata[s.beat];
        next_s.tmr       = 4'(`NIB_CYC - 1 + `SYNC_CYC);
        next_s.st        = dram_pkg::S_COL;
      end
      dram_pkg::S_ROR: begin
        // column strobe stays high for the whole cycle
        if (s.pin.ras_n && done) begin
          next_s.pin.ras_n = 1'b0;
          next_s.tmr       = 4'(`RAS_CYC - 1);
        end else if (done) begin
          next_s.pin.ras_n = 1'b1;
          next_s.row_ctr   = s.row_ctr + 9'h001;
          next_s.tmr       = 4'(`RP_CYC - 1);
          ref_done         = 1'b1;
          next_s.st        = dram_pkg::S_IDLE;
        end
      end
      dram_pkg::S_CBR, dram_pkg::S_HID: begin
        // column is already low; the row pulse uses the internal counter
        if (s.pin.ras_n && done) begin
          next_s.pin.ras_n = 1'b0;
          next_s.tmr       = 4'(`RAS_CYC - 1);
        end else if (done) begin
          // hold time is covered by the row low width
          next_s.pin.ras_n = 1'b1;
          next_s.pin.cas_n = 1'b1;
          next_s.tmr       = 4'(`RP_CYC - 1);
          ref_done         = 1'b1;
          next_s.st        = dram_pkg::S_IDLE;
        end
      end
      default: begin
        next_s.st = dram_pkg::S_IDLE;
      end
    endcase
    // owed refresh count: interval adds one below 15, each finished refresh takes one
    next_s.pend = s.pend + {3'h0, tick_inc} - {3'h0, ref_done};
  end

  // state register; strobes and write enable idle high after reset, address and data low
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      s           <= '0;
      s.tick      <= 9'h000;
      s.pin.ras_n <= 1'b1;
      s.pin.cas_n <= 1'b1;
      s.pin.we_n  <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // checks on the pin sequences
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!nrst);

  property p_ras_only_cas_high;
    s.st == dram_pkg::S_ROR |-> cas_n;
  endproperty
  a_ras_only_cas_high: assert property (p_ras_only_cas_high)
    else $error("column strobe low during row-only refresh");

  property p_no_write_in_refresh;
    refreshing |-> we_n;
  endproperty
  a_no_write_in_refresh: assert property (p_no_write_in_refresh)
    else $error("write enable low during refresh");

  property p_cbr_order;
    $fell(ras_n) |-> cas_n || ($past(cas_n) == 1'b0);
  endproperty
  a_cbr_order: assert property (p_cbr_order)
    else $error("column strobe not set up before row strobe fell");

  property p_cbr_hold;
    $fell(ras_n) && !cas_n |-> !cas_n [*3];
  endproperty
  a_cbr_hold: assert property (p_cbr_hold)
    else $error("column strobe released too early in refresh");

  property p_ras_low_width;
    $fell(ras_n) |-> !ras_n [*3];
  endproperty
  a_ras_low_width: assert property (p_ras_low_width)
    else $error("row strobe low pulse too short");

  property p_precharge;
    $rose(ras_n) |-> ras_n [*2];
  endproperty
  a_precharge: assert property (p_precharge)
    else $error("row strobe precharge too short");

  property p_nibble_addr_still;
    s.st == dram_pkg::S_NIB |-> $stable(addr) ##1 $stable(addr);
  endproperty
  a_nibble_addr_still: assert property (p_nibble_addr_still)
    else $error("address moved during a nibble beat");

  property p_static_strobes;
    s.st == dram_pkg::S_COL && s.req.mode == dram_pkg::MODE_STATIC && s.beat != 2'h0
      |-> !cas_n && !ras_n;
  endproperty
  a_static_strobes: assert property (p_static_strobes)
    else $error("strobe released inside static column burst");

  property p_urgent_wins;
    s.st == dram_pkg::S_IDLE && done && urgent
      |=> s.st inside {dram_pkg::S_ROR, dram_pkg::S_CBR};
  endproperty
  a_urgent_wins: assert property (p_urgent_wins)
    else $error("urgent refresh lost arbitration");

  property p_row_counter_step;
    $rose(ras_n) && $past(s.st) == dram_pkg::S_ROR
      |-> s.row_ctr == 9'($past(s.row_ctr) + 9'h001);
  endproperty
  a_row_counter_step: assert property (p_row_counter_step)
    else $error("row counter did not advance after row-only refresh");

  property p_beats_bounded;
    s.st == dram_pkg::S_COL |-> s.beat <= s.req.extra;
  endproperty
  a_beats_bounded: assert property (p_beats_bounded)
    else $error("more beats than requested");

  property p_interval_owes;
    s.tick == 9'h000 && s.pend == 4'h0 |=> s.pend == 4'h1;
  endproperty
  a_interval_owes: assert property (p_interval_owes)
    else $error("refresh interval did not raise the owed count");

  property p_ror_row_addr;
    $fell(ras_n) && s.st == dram_pkg::S_ROR |-> addr == {1'b0, s.row_ctr};
  endproperty
  a_ror_row_addr: assert property (p_ror_row_addr)
    else $error("row-only refresh strobed the wrong row address");

  property p_row_ctr_only_ror;
    s.st != dram_pkg::S_ROR |=> $stable(s.row_ctr);
  endproperty
  a_row_ctr_only_ror: assert property (p_row_ctr_only_ror)
    else $error("refresh row counter moved outside row-only refresh");

  property p_hidden_after_random;
    $rose(ras_n) && !cas_n |-> s.req.mode == dram_pkg::MODE_RANDOM;
  endproperty
  a_hidden_after_random: assert property (p_hidden_after_random)
    else $error("hidden refresh started after a fast-mode access");

  property p_hidden_cas_low;
    s.st == dram_pkg::S_HID |-> !cas_n;
  endproperty
  a_hidden_cas_low: assert property (p_hidden_cas_low)
    else $error("column strobe released inside hidden refresh");

  property p_nibble_ras_low;
    s.st == dram_pkg::S_NIB |-> !ras_n && cas_n;
  endproperty
  a_nibble_ras_low: assert property (p_nibble_ras_low)
    else $error("row strobe high between nibble beats");

  property p_write_under_strobes;
    !we_n |-> !cas_n && !ras_n;
  endproperty
  a_write_under_strobes: assert property (p_write_under_strobes)
    else $error("write enable low outside an access");

  property p_precharge_before_fall;
    $fell(ras_n) |-> $past(ras_n, 2);
  endproperty
  a_precharge_before_fall: assert property (p_precharge_before_fall)
    else $error("row strobe fell before precharge ended");

endmodule
`default_nettype wire

// [tb/dram_model.sv]
// behavioural 1M x 1 dynamic ram standing at the pins of the controller
// assumes strobes, address and data come from registered controller pins
`timescale 1ns/1ps
`default_nettype none
module dram_model #(
  parameter int PERIOD_NS = 204800
) (
  input  wire logic       ras_n,
  input  wire logic       cas_n,
  input  wire logic       we_n,
  input  wire logic [9:0] addr,
  input  wire logic       d,
  output logic            q,
  output int              viol
);
  bit         mem [bit [19:0]];
  time        last_ref [512];
  time        t_rf = 0;
  time        t_rr = 0;
  time        t_ok = 0;
  logic [9:0] row = 10'h000;
  logic [9:0] col = 10'h000;
  logic [8:0] ictr = 9'h000;
  logic       refr = 1'b0;
  logic       ok = 1'b0;
  int         ncas = 0;

  initial begin
    viol = 0;
    q = 1'b0;
    foreach (last_ref[i]) last_ref[i] = 0;
  end

  //////////////////////////////////////////////////////////////
  // row strobe falling: open a row, or refresh from the own counter
  always @(negedge ras_n) begin
    if (t_rr > 0 && $time - t_rr < 80) viol++;
    if (!cas_n) begin
      refr = 1'b1;
      last_ref[ictr] = $time;
      ictr++;
      if (!we_n) viol++;
    end else begin
      refr = 1'b0;
      row = addr;
      ncas = 0;
      last_ref[addr[8:0]] = $time;
    end
    t_rf = $time;
  end

  // low width of every row cycle; the x to 1 edge at start is skipped
  always @(posedge ras_n) begin
    if (t_rf > 0 && $time - t_rf < 85) viol++;
    t_rr = $time;
  end

  // column strobe: first fall takes the address, later falls step in four
  always @(negedge cas_n) begin
    if (!ras_n && !refr) begin
      col = (ncas == 0) ? addr : {col[9:2], col[1:0] + 2'h1};
      t_ok = (ncas == 0) ? t_rf + 85 : $time + 20;
      ncas++;
      ok = 1'b1;
    end
  end

  always @(posedge cas_n) begin
    if (refr && !ras_n && $time - t_rf < 15) viol++;
    ok = 1'b0;
  end

  // static column: a new address under both strobes picks a new column
  always @(addr) begin
    if (!ras_n && !cas_n && !refr && ncas > 0) begin
      col = addr;
      t_ok = $time + 45;
    end
  end

  // write lands a moment later so the column update above settles first
  always @(negedge cas_n or negedge we_n or addr or d) begin
    #1;
    if (refr && !cas_n && !we_n) viol++;
    if (!ras_n && !cas_n && !we_n && !refr && ok) mem[{row, col}] = d;
  end

  // data only after the access delay; otherwise a toggling pattern
  always begin
    #5;
    if (!cas_n && we_n && ok && $time >= t_ok) q = mem[{row, col}];
    else q = ~q;
  end

  // rows whose last refresh is older than the period plus a little jitter
  task automatic stale_rows(output int n);
    n = 0;
    foreach (last_ref[i]) if ($time - last_ref[i] > PERIOD_NS + 800) n++;
  endtask

endmodule
`default_nettype wire

// [tb/dram_fast_modes_refresh_tb.sv]
// self-checking bench: random, nibble and static accesses, fifo stall, refresh
// assumes the design package, the fifo and tb/dram_model.sv are compiled first
`timescale 1ns/1ps
`default_nettype none
module dram_fast_modes_refresh_tb;
  localparam int RP = 5120;
  logic                  clock = 1'b0;
  logic                  nrst = 1'b0;
  dram_pkg::req_t        req = '0;
  logic                  req_valid = 1'b0;
  logic                  rd_ready = 1'b0;
  dram_pkg::ref_method_t ref_method = dram_pkg::REF_CBR;
  logic                  req_ready;
  logic                  rd_data;
  logic                  rd_valid;
  logic                  refreshing;
  logic                  ras_n;
  logic                  cas_n;
  logic                  we_n;
  logic                  d;
  logic                  q;
  logic [9:0]            addr;
  int                    viol;
  int                    stale;
  int                    nref = 0;
  int                    err_total = 0;
  int                    n_tests = 0;
  bit [31:0]             rs = 32'h0000cc78;
  bit                    rd_rand = 1'b0;
  bit                    ref_mem [bit [19:0]];
  bit                    exp_q [$];

  dram_fast_modes_refresh #(.REFRESH_PERIOD_CYC(RP)) i_dut (
    .clock(clock), .nrst(nrst), .req(req), .req_valid(req_valid), .req_ready(req_ready),
    .ref_method(ref_method), .rd_data(rd_data), .rd_valid(rd_valid), .rd_ready(rd_ready),
    .refreshing(refreshing), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .addr(addr),
    .d(d), .q(q));

  dram_model #(.PERIOD_NS(RP * 40)) i_model (
    .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .addr(addr), .d(d), .q(q), .viol(viol));

  initial begin
    forever #20 clock = ~clock;
  end

  function automatic bit [31:0] rnd();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs;
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic test_done();
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  //////////////////////////////////////////////////////////////
  // the reference memory predicts read bits in beat order, then the request waits
  task automatic do_req(input bit wr, input dram_pkg::mode_t m, input bit [1:0] ex,
                        input bit [19:0] a, input bit [3:0] wd);
    int        k;
    bit [19:0] ba;
    for (int n = 0; n <= ex; n++) begin
      ba = {a[19:2], a[1:0] + n[1:0]};
      if (wr) ref_mem[ba] = wd[n];
      else exp_q.push_back(ref_mem[ba]);
    end
    @(posedge clock);
    req <= '{wr, m, ex, a, wd};
    req_valid <= 1'b1;
    k = 0;
    do begin
      @(posedge clock);
      k++;
    end while (req_ready !== 1'b1 && k < 300);
    check(k < 300, 1);
    req_valid <= 1'b0;
  endtask

  task automatic drain();
    int k;
    k = 0;
    while (exp_q.size() > 0 && k < 3000) begin
      @(posedge clock);
      k++;
    end
    check(exp_q.size(), 0);
    check(viol, 0);
  endtask

  // every popped bit against the oldest prediction; ready stalls at random
  always @(posedge clock) begin
    if (rd_valid === 1'b1 && rd_ready === 1'b1) begin
      check(rd_data, exp_q.size() > 0 ? exp_q.pop_front() : 2);
    end
    rd_ready <= rd_rand && (rnd() % 4 != 0);
  end

  // refresh row cycles counted as the row strobe falls under a refresh
  always @(negedge ras_n) begin
    if (refreshing === 1'b1) nref++;
  end

  initial begin
    repeat (8000 + 3 * RP) @(posedge clock);
    err_total++;
    test_done();
  end

  initial begin
    bit [19:0] a;
    bit [3:0]  w;
    repeat (5) @(posedge clock);
    check({ras_n, cas_n, we_n, addr, d, rd_valid, refreshing}, {3'h7, 13'h0000});
    nrst <= 1'b1;
    rd_rand <= 1'b1;
    // random writes and reads, cycling the refresh method so hidden ones follow
    for (int i = 0; i < 12; i++) begin
      ref_method <= dram_pkg::ref_method_t'(i % 3);
      a = 20'(rnd());
      w = 4'(rnd());
      do_req(1'b1, dram_pkg::MODE_RANDOM, 2'h0, a, w);
      do_req(1'b0, dram_pkg::MODE_RANDOM, 2'h0, a, 4'h0);
    end
    drain();
    $display("test random done");
    // nibble from the last column wraps; static from column 0 walks up
    for (int i = 1; i < 3; i++) begin
      a = 20'(rnd());
      a[1:0] = (i == 1) ? 2'h3 : 2'h0;
      w = 4'(rnd());
      do_req(1'b1, dram_pkg::mode_t'(i), 2'h3, a, w);
      do_req(1'b0, dram_pkg::mode_t'(i), 2'h3, a, 4'h0);
      for (int n = 0; n < 4; n++) begin
        do_req(1'b0, dram_pkg::MODE_RANDOM, 2'h0, {a[19:2], n[1:0]}, 4'h0);
      end
    end
    drain();
    $display("test modes done");
    // fifo filled to refusal: the fifth read must hold its column strobe low
    rd_rand <= 1'b0;
    repeat (3) @(posedge clock);
    for (int i = 0; i < 5; i++) do_req(1'b0, dram_pkg::MODE_STATIC, 2'h3, a, 4'h0);
    repeat (40) @(posedge clock);
    check({rd_valid, cas_n, refreshing}, 3'h4);
    rd_rand <= 1'b1;
    drain();
    $display("test fifo done");
    // idle refresh with the own row counter, then with the device counter
    for (int i = 0; i < 2; i++) begin
      ref_method <= (i == 0) ? dram_pkg::REF_RAS_ONLY : dram_pkg::REF_CBR;
      repeat (RP / 4) @(posedge clock);
      nref = 0;
      repeat (RP) @(posedge clock);
      check(nref inside {[511:513]}, 1);
      i_model.stale_rows(stale);
      check(stale, 0);
    end
    check(viol, 0);
    $display("test refresh done");
    test_done();
  end

endmodule
`default_nettype wire
